// *** asr_ctrl.sv ***
// Host controller driving a 512K x 8 asynchronous static memory
//
// Behaviour
// - Drive 19-bit address and share one 8-bit two-way data bus.
// - Each read cycle lasts at least 55 ns between address changes.
// - Each write cycle lasts at least 55 ns between address changes.
// - Select and address valid at least 50 ns before write end.
// - Address stable by write strobe start and held after it ends.
// - Write enable pulse stays low at least 45 ns.
// - Data set up 30 or 40 ns before write end, held after.
// - Write ends on first rising strobe; meet that strobe's data set-up.
// - Contents undefined at power-up; write before reading, verify reads.
`timescale 1ns/1ps
`default_nettype none

module asr_ctrl
    import asr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire asr_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [ASR_DATA_W-1:0] rsp_data,
    output asr_pins_t pins,
    output logic [ASR_DATA_W-1:0] mem_dq_o,
    output logic mem_dq_oe_n,
    input wire logic [ASR_DATA_W-1:0] mem_dq_i
);

    asr_state_t state_ff;
    asr_state_t nxt_state;
    asr_req_t req_ff;
    logic ready_ff;
    logic rsp_valid_ff;
    logic [ASR_DATA_W-1:0] rsp_data_ff;
    asr_pins_t pins_ff;
    logic [ASR_DATA_W-1:0] dq_o_ff;
    logic dq_oe_n_ff;
    logic [ASR_DATA_W-1:0] dq_s1_ff;
    logic [ASR_DATA_W-1:0] dq_s2_ff;
    logic cnt_load;
    logic [CNT_W-1:0] cnt_value;
    logic cnt_done;

    // ----------------------------------------------------------------
    // Phase timer
    // ----------------------------------------------------------------
    asr_cnt #(
        .W(CNT_W)
    ) u_cnt (
        .clk(clk),
        .rst(rst),
        .load(cnt_load),
        .value(cnt_value),
        .done(cnt_done)
    );

    // ----------------------------------------------------------------
    // Data input synchroniser
    // ----------------------------------------------------------------
    // Bus comes from an unclocked part, so two flops before use
    always_ff @(posedge clk) begin
        if (rst) begin
            dq_s1_ff <= '0;
            dq_s2_ff <= '0;
        end else begin
            dq_s1_ff <= mem_dq_i;
            dq_s2_ff <= dq_s1_ff;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Every phase is at least one 100 ns cycle, so all least times hold
    always_comb begin
        nxt_state = state_ff;
        cnt_load = 1'b0;
        cnt_value = '0;
        case (state_ff)
            ASR_IDLE: begin
                if (req_valid && ready_ff) begin
                    cnt_load = 1'b1;
                    if (req.we) begin
                        nxt_state = ASR_WR_SET;
                        cnt_value = CNT_W'(TURN_CYC);
                    end else begin
                        nxt_state = ASR_RD;
                        // Two extra cycles cover the input synchroniser
                        cnt_value = CNT_W'(READ_WAIT_CYC + 2);
                    end
                end
            end
            ASR_RD: begin
                if (cnt_done) begin
                    nxt_state = ASR_RD_END;
                end
            end
            ASR_RD_END: begin
                nxt_state = ASR_IDLE;
            end
            ASR_WR_SET: begin
                if (cnt_done) begin
                    nxt_state = ASR_WR;
                    cnt_load = 1'b1;
                    cnt_value = CNT_W'(WRITE_PULSE_CYC);
                end
            end
            ASR_WR: begin
                if (cnt_done) begin
                    nxt_state = ASR_WR_END;
                end
            end
            ASR_WR_END: begin
                nxt_state = ASR_IDLE;
            end
            default: begin
                nxt_state = ASR_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= ASR_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // Request capture and handshake
    // ----------------------------------------------------------------
    // Address and data frozen for the whole access
    always_ff @(posedge clk) begin
        if (rst) begin
            req_ff <= '0;
            ready_ff <= 1'b0;
        end else begin
            if (state_ff == ASR_IDLE && req_valid && ready_ff) begin
                req_ff <= req;
            end
            ready_ff <= (nxt_state == ASR_IDLE);
        end
    end

    // ----------------------------------------------------------------
    // Memory strobes
    // ----------------------------------------------------------------
    // Address changes only while select is high, so each access stands
    // alone; cycle length is at least three clocks, far above 55 ns
    always_ff @(posedge clk) begin
        if (rst) begin
            pins_ff <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0};
        end else begin
            case (nxt_state)
                ASR_RD: begin
                    pins_ff.cs_n <= 1'b0;
                    pins_ff.oe_n <= 1'b0;
                    pins_ff.we_n <= 1'b1;
                    if (state_ff == ASR_IDLE) begin
                        pins_ff.addr <= req.addr;
                    end
                end
                ASR_WR_SET: begin
                    // Select first, write strobe later; output enable stays high
                    pins_ff.cs_n <= 1'b0;
                    pins_ff.oe_n <= 1'b1;
                    pins_ff.we_n <= 1'b1;
                    pins_ff.addr <= req.addr;
                end
                ASR_WR: begin
                    pins_ff.cs_n <= 1'b0;
                    pins_ff.oe_n <= 1'b1;
                    pins_ff.we_n <= 1'b0;
                end
                default: begin
                    // Both strobes rise together; write enable ends the write
                    pins_ff.cs_n <= 1'b1;
                    pins_ff.oe_n <= 1'b1;
                    pins_ff.we_n <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Data bus drive
    // ----------------------------------------------------------------
    // Drive from the write strobe's fall through one cycle after the strobe rises
    always_ff @(posedge clk) begin
        if (rst) begin
            dq_o_ff <= '0;
            dq_oe_n_ff <= 1'b1;
        end else begin
            if (nxt_state == ASR_WR) begin
                dq_o_ff <= req_ff.wdata;
                dq_oe_n_ff <= 1'b0;
            end else if (nxt_state != ASR_WR_END) begin
                dq_oe_n_ff <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read answer
    // ----------------------------------------------------------------
    // Sample before select rises, never after, as no hold is promised
    always_ff @(posedge clk) begin
        if (rst) begin
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= '0;
        end else begin
            rsp_valid_ff <= 1'b0;
            if (state_ff == ASR_RD && cnt_done) begin
                rsp_valid_ff <= 1'b1;
                rsp_data_ff <= dq_s2_ff;
            end
        end
    end

    assign req_ready = ready_ff;
    assign rsp_valid = rsp_valid_ff;
    assign rsp_data = rsp_data_ff;
    assign pins = pins_ff;
    assign mem_dq_o = dq_o_ff;
    assign mem_dq_oe_n = dq_oe_n_ff;

endmodule

`default_nettype wire

// *** asr_pkg.sv ***
// Package with the controller's timing constants, states and carrier structs
package asr_pkg;

    // ----------------------------------------------------------------
    // Memory geometry
    // ----------------------------------------------------------------
    localparam int ASR_ADDR_W = 19;
    localparam int ASR_DATA_W = 8;

    // ----------------------------------------------------------------
    // Timing of the memory, in ns as printed
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int READ_CYCLE_TIME_NS = 55;
    localparam int ADDRESS_ACCESS_TIME_NS = 55;
    localparam int OUTPUT_ENABLE_ACCESS_TIME_NS = 30;
    localparam int OUTPUT_DISABLE_TO_HIGH_Z_NS = 20;
    localparam int WRITE_CYCLE_TIME_NS = 55;
    localparam int SELECT_TO_WRITE_END_NS = 50;
    localparam int ADDRESS_VALID_TO_WRITE_END_NS = 50;
    localparam int WRITE_PULSE_WIDTH_NS = 45;
    localparam int WRITE_DATA_SETUP_NS = 40;

    // ----------------------------------------------------------------
    // Derived cycle counts, least times rounded up, never below one
    // ----------------------------------------------------------------
    function automatic int ceil_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int READ_WAIT_CYC = ceil_cyc(ADDRESS_ACCESS_TIME_NS);
    localparam int WRITE_PULSE_CYC = ceil_cyc(WRITE_PULSE_WIDTH_NS);
    localparam int TURN_CYC = ceil_cyc(OUTPUT_DISABLE_TO_HIGH_Z_NS);
    localparam int CNT_W = 4;

    // ----------------------------------------------------------------
    // Controller states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        ASR_IDLE = 6'h01,
        ASR_RD = 6'h02,
        ASR_RD_END = 6'h04,
        ASR_WR_SET = 6'h08,
        ASR_WR = 6'h10,
        ASR_WR_END = 6'h20
    } asr_state_t;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic we;
        logic [ASR_ADDR_W-1:0] addr;
        logic [ASR_DATA_W-1:0] wdata;
    } asr_req_t;

    typedef struct packed {
        logic cs_n;
        logic oe_n;
        logic we_n;
        logic [ASR_ADDR_W-1:0] addr;
    } asr_pins_t;

endpackage

// *** asr_cnt.sv ***
// Down counter that times each memory phase in whole clock cycles
`timescale 1ns/1ps
`default_nettype none

module asr_cnt
    import asr_pkg::*;
#(
    parameter int W = CNT_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic done
);

    logic [W-1:0] cnt_ff;

    // ----------------------------------------------------------------
    // Count
    // ----------------------------------------------------------------
    // Load wins over counting so a phase always gets its full length
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= '0;
        end else if (load) begin
            cnt_ff <= value;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    // Done when the last cycle of the phase is running; load is kept out
    // so a caller may reload on done without a combinational loop
    assign done = (cnt_ff <= {{(W-1){1'b0}}, 1'b1});

endmodule

`default_nettype wire

// *** asr_mem_model.sv ***
// Behavioural model of the 512K x 8 asynchronous static memory
`timescale 1ns/1ps
`default_nettype none

module asr_mem_model
    import asr_pkg::*;
(
    input wire logic cs_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [ASR_ADDR_W-1:0] addr,
    input wire logic [ASR_DATA_W-1:0] dq,
    input wire logic slow,
    output logic drv,
    output logic [ASR_DATA_W-1:0] q
);
    // ------------------------------------------------
    // Storage and strobes
    // ------------------------------------------------
    logic [ASR_DATA_W-1:0] mem [logic [ASR_ADDR_W-1:0]];
    logic rd_ok = 1'b0;
    logic wr_on = 1'b0;

    // Data turns good only after the access time; slow uses the full figure
    always @(cs_n or oe_n or we_n or addr or slow) begin
        rd_ok = 1'b0;
        rd_ok <= #(slow ? 55 : 5) (!cs_n && !oe_n && we_n);
    end

    // Leaving the read state floats the bus at once
    assign drv = rd_ok && !cs_n && !oe_n && we_n;

    // Unwritten words read back as junk, not as zero
    always @(addr or drv) q = mem.exists(addr) ? mem[addr] : ~addr[7:0];

    // A write lands when the first strobe rises
    always @(negedge we_n or negedge cs_n) wr_on = !we_n && !cs_n;
    always @(posedge we_n or posedge cs_n) begin
        if (wr_on) mem[addr] = dq;
        wr_on = 1'b0;
    end
endmodule

`default_nettype wire

// *** asr_ctrl_monitor.sv ***
// Checker of the controller's memory pin sequencing
`timescale 1ns/1ps
`default_nettype none

module asr_ctrl_monitor
    import asr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire asr_req_t req,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [ASR_DATA_W-1:0] rsp_data,
    input wire asr_pins_t pins,
    input wire logic [ASR_DATA_W-1:0] mem_dq_o,
    input wire logic mem_dq_oe_n,
    input wire logic [ASR_DATA_W-1:0] mem_dq_i
);
    // ------------------------------------------------
    // Pin timing and read answer delay
    // ------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_oe_quiet_wr: assert property (
        (!pins.we_n || !mem_dq_oe_n) |-> pins.oe_n) else $error("oe low in write");
    a_we_pulse: assert property (
        $fell(pins.we_n) |-> !pins.cs_n ##1 (pins.we_n && pins.cs_n)) else $error("we pulse");
    a_data_setup: assert property (
        $fell(pins.we_n) |-> !mem_dq_oe_n ##1 (!mem_dq_oe_n && $stable(mem_dq_o)))
        else $error("write data");
    a_wr_select: assert property (
        $fell(pins.we_n) |-> !$past(pins.cs_n) && $stable(pins.addr)) else $error("wr select");
    a_wr_start: assert property (
        (req_valid && req_ready && req.we) |=> (!pins.cs_n && pins.oe_n
        && pins.addr == $past(req.addr)) ##1 (!pins.we_n && mem_dq_o == $past(req.wdata, 2)))
        else $error("write start");
    a_rd_start: assert property (
        (req_valid && req_ready && !req.we) |=> !pins.cs_n && !pins.oe_n && pins.we_n
        && pins.addr == $past(req.addr)) else $error("read start");
    a_rd_hold: assert property (
        $fell(pins.oe_n) |-> !pins.cs_n ##1 (!pins.oe_n && !pins.cs_n && $stable(pins.addr))[*2]
        ##1 (pins.oe_n && pins.cs_n)) else $error("read strobes");
    a_rsp_time: assert property (
        (req_valid && req_ready && !req.we) |-> ##4 rsp_valid) else $error("read answer");
endmodule

bind asr_ctrl asr_ctrl_monitor u_mon (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins),
    .mem_dq_o(mem_dq_o), .mem_dq_oe_n(mem_dq_oe_n), .mem_dq_i(mem_dq_i));

`default_nettype wire

// *** asr_ctrl_tb_top.sv ***
// Testbench of the memory controller against a behavioural memory
`timescale 1ns/1ps
`default_nettype none

module asr_ctrl_tb_top
    import asr_pkg::*;
();
    // ------------------------------------------------
    // Signals and bus
    // ------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    asr_req_t req = '0;
    logic req_ready, rsp_valid, mem_dq_oe_n, drv;
    logic slow = 1'b0;
    logic [ASR_DATA_W-1:0] rsp_data, mem_dq_o, q, dq;
    logic [ASR_DATA_W-1:0] last_dq = '0;
    asr_pins_t pins;
    logic [ASR_DATA_W-1:0] sb [logic [ASR_ADDR_W-1:0]];
    int failures = 0;
    int n_compared = 0;

    always #50 clk = ~clk;

    // Undriven bus wanders so a stale byte never passes for data
    always @* begin
        if (!mem_dq_oe_n) dq = mem_dq_o;
        else if (drv) dq = q;
        else dq = ~last_dq;
    end
    always @(posedge clk) last_dq <= dq;

    asr_ctrl uut (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins), .mem_dq_o(mem_dq_o),
        .mem_dq_oe_n(mem_dq_oe_n), .mem_dq_i(dq));
    asr_mem_model u_mem (.cs_n(pins.cs_n), .oe_n(pins.oe_n), .we_n(pins.we_n),
        .addr(pins.addr), .dq(dq), .slow(slow), .drv(drv), .q(q));

    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task automatic give_verdict();
        if (failures == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic ok, input string what);
        n_compared++;
        if (!ok) begin
            failures++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    function automatic logic [ASR_DATA_W-1:0] exp_of(input logic [ASR_ADDR_W-1:0] a);
        return sb[a];
    endfunction

    // One access; request held until an edge with ready high takes it
    task automatic access(input logic we, input logic [ASR_ADDR_W-1:0] a,
        input logic [ASR_DATA_W-1:0] d);
        int i;
        logic taken;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{we, a, d};
        taken = 1'b0;
        // Ready only moves on rising edges, so the negedge value is what is taken
        for (i = 0; i < 40 && !taken; i++) begin
            @(negedge clk);
            taken = (req_ready === 1'b1);
            @(posedge clk);
        end
        req_valid <= 1'b0;
        if (!taken) begin
            failures++;
            give_verdict();
        end
        if (we) sb[a] = d;
        else begin
            for (i = 0; i < 10 && rsp_valid !== 1'b1; i++) @(negedge clk);
            check(rsp_valid === 1'b1 && rsp_data === exp_of(a), "read data");
        end
    endtask

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        int i;
        logic [ASR_ADDR_W-1:0] a;
        logic [ASR_ADDR_W-1:0] al [$];
        i = $urandom(88062);
        repeat (12) @(posedge clk);
        check(pins.cs_n === 1'b1 && pins.we_n === 1'b1 && mem_dq_oe_n === 1'b1, "idle");
        rst <= 1'b0;
        // Corner addresses and an overwrite of one word
        access(1'b1, 19'h00000, 8'h00);
        access(1'b1, 19'h7ffff, 8'hff);
        access(1'b1, 19'h12345, 8'h5a);
        access(1'b1, 19'h12345, 8'ha5);
        for (i = 0; i < 40; i++) begin
            a = 19'($urandom);
            al.push_back(a);
            access(1'b1, a, 8'($urandom));
        end
        access(1'b0, 19'h00000, 8'h00);
        access(1'b0, 19'h7ffff, 8'h00);
        access(1'b0, 19'h12345, 8'h00);
        // Fast and slow memory answers alternate
        foreach (al[k]) begin
            slow <= ~slow;
            access(1'b0, al[k], 8'h00);
        end
        // Reset in a write's end state, after select and write enable have risen, must keep them high and drop ready
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{1'b1, 19'h00000, 8'h3c};
        repeat (3) @(posedge clk);
        rst <= 1'b1;
        req_valid <= 1'b0;
        repeat (2) @(negedge clk);
        check(pins.cs_n === 1'b1 && pins.we_n === 1'b1 && req_ready === 1'b0, "reset");
        @(posedge clk);
        rst <= 1'b0;
        sb.delete(19'h00000);
        access(1'b1, 19'h00001, 8'h77);
        access(1'b0, 19'h00001, 8'h00);
        give_verdict();
    end
endmodule

`default_nettype wire
